// ==== src/mrsfh_slave.sv ====
// slave end: read data fifo and query check, execute and response logic
module mrsfh_fifo import mrsfh_pkg::*; #(
  parameter int W = 16,
  parameter int D = RD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic room_reg;
  wire push = in_valid & room_reg;
  wire pop = out_ready & (cnt_reg != '0);
  assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = room_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      room_reg <= 1'b1;
    end else begin
      wr_reg <= push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= cnt_next;
      room_reg <= cnt_next != (AW+1)'(D);
    end
  end
endmodule

module mrsfh_slave import mrsfh_pkg::*; #(
  parameter int CHAR_CYCLES = CHAR_CYCLES_DEF,
  parameter int SILENCE_CYCLES = SILENCE_CYCLES_DEF,
  parameter int FIFO_DEPTH = RD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link to the master
  mrsfh_link_if.slave link,
  // configuration and status from the driver
  input wire logic [7:0] station_addr,
  input wire logic slave_busy,
  // operation request
  output logic exec_valid,
  output logic [7:0] exec_func,
  output logic [15:0] exec_addr,
  output logic [15:0] exec_count,
  output logic exec_bcast,
  // read data words for responses
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic rd_ready,
  // events
  output logic frame_drop,
  output logic comm_err
);
  typedef enum {S_RX, S_EVAL, S_HDR, S_DATA, S_CRCL, S_CRCH, S_END} mrsfh_state_t;
  mrsfh_state_t st_reg;
  logic [7:0] buf_mem [MAX_FRAME];
  logic [8:0] len_reg;
  logic ovf_reg, err_reg, quiet_reg;
  logic [31:0] gap_reg, pace_reg;
  logic [15:0] crc_reg, crc_d1_reg, crc_d2_reg, tx_crc_reg;
  logic [7:0] exc_reg, tx_idx_reg;
  logic [15:0] words_reg;
  logic lo_reg;
  logic [7:0] hlen_reg;
  logic s2m_valid_reg, drive_reg, exec_valid_reg, drop_reg, cerr_reg, bcast_reg;
  logic [7:0] s2m_data_reg, func_reg;
  logic [15:0] eaddr_reg, ecount_reg;
  logic [7:0] exc;
  logic fifo_valid;
  logic [15:0] fifo_data;

  // query fields
  wire [7:0] q_addr = buf_mem[0];
  wire [7:0] q_fc = buf_mem[1];
  wire [15:0] q_p1 = {buf_mem[2], buf_mem[3]};
  wire [15:0] q_p2 = {buf_mem[4], buf_mem[5]};
  wire [15:0] q_p3 = {buf_mem[6], buf_mem[7]};
  wire [15:0] q_p4 = {buf_mem[8], buf_mem[9]};
  wire [7:0] q_bc6 = buf_mem[6];
  wire [7:0] q_bc10 = buf_mem[10];
  wire [15:0] crc_rx = {buf_mem[8'(len_reg - 9'd1)], buf_mem[8'(len_reg - 9'd2)]};
  wire crc_ok = crc_d2_reg == crc_rx;
  wire good = ~err_reg & ~ovf_reg & (len_reg >= MIN_FRAME) & crc_ok;
  wire bcast = q_addr == BCAST_ADDR;
  wire mine = q_addr == station_addr;
  wire bc_ok = (q_fc == FC_WRITE1) | (q_fc == FC_WRITEN);
  wire rd_fn = (q_fc == FC_READ) | (q_fc == FC_RDWR);
  wire [16:0] end1 = {1'b0, q_p1} + {1'b0, q_p2};
  wire [16:0] end3 = {1'b0, q_p3} + {1'b0, q_p4};
  wire in1 = (end1 <= REG_LIMIT);
  wire cnt_rd = (q_p2 != '0) & (q_p2 <= RD_MAX);
  wire frame_end = (st_reg == S_RX) & (len_reg != '0) & (gap_reg == 32'(SILENCE_CYCLES - 1));
  wire tick = pace_reg == 32'(CHAR_CYCLES - 1);
  wire last_hdr = tx_idx_reg == 8'(hlen_reg - 8'd1);
  wire fifo_pop = (st_reg == S_DATA) & tick & lo_reg & fifo_valid;

  always_comb begin
    exc = EXC_NONE;
    case (q_fc)
      FC_READ: begin
        if (!cnt_rd) exc = EXC_DATA;
        else if (!in1) exc = EXC_ADDR;
      end
      FC_WRITE1: begin
        if (len_reg != WRITE1_LEN) exc = EXC_DATA;
        else if ({1'b0, q_p1} >= REG_LIMIT) exc = EXC_ADDR;
      end
      FC_DIAG: begin
        if (q_p1 != DIAG_SUB) exc = EXC_FUNC;
      end
      FC_WRITEN: begin
        if (q_p2 == '0 || q_p2 > WRN_MAX || {8'h00, q_bc6} != {q_p2[14:0], 1'b0}) exc = EXC_DATA;
        else if (!in1) exc = EXC_ADDR;
      end
      FC_RDWR: begin
        if (!cnt_rd || q_p4 == '0 || q_p4 > RW_WMAX || {8'h00, q_bc10} != {q_p4[14:0], 1'b0}) exc = EXC_DATA;
        else if (!in1 || end3 > REG_LIMIT) exc = EXC_ADDR;
      end
      default: exc = EXC_FUNC;
    endcase
    if (exc == EXC_NONE && slave_busy) exc = EXC_BUSY;
  end

  // outgoing header byte: echo, or exception / byte-count substitution
  wire [7:0] hdr_byte = (tx_idx_reg == 8'd1 && exc_reg != EXC_NONE) ? (q_fc | EXC_FLAG) :
                        (tx_idx_reg == 8'd2 && exc_reg != EXC_NONE) ? exc_reg :
                        (tx_idx_reg == 8'd2 && words_reg != '0) ? {words_reg[6:0], 1'b0} :
                        buf_mem[tx_idx_reg];
  wire [7:0] data_byte = lo_reg ? fifo_data[7:0] : fifo_data[15:8];
  wire exec_go = (st_reg == S_EVAL) & good & (exc == EXC_NONE) & (bcast ? bc_ok : mine);

  mrsfh_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(rd_valid),
    .in_data(rd_data),
    .in_ready(rd_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge core_clk) begin
    if (st_reg == S_RX && link.m2s_valid && len_reg < 9'(MAX_FRAME)) begin
      buf_mem[len_reg[7:0]] <= link.m2s_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= S_RX;
      len_reg <= '0;
      ovf_reg <= 1'b0;
      err_reg <= 1'b0;
      quiet_reg <= 1'b0;
      gap_reg <= '0;
      pace_reg <= '0;
      crc_reg <= CRC_PRESET;
      crc_d1_reg <= CRC_PRESET;
      crc_d2_reg <= CRC_PRESET;
      tx_crc_reg <= CRC_PRESET;
      exc_reg <= EXC_NONE;
      tx_idx_reg <= '0;
      words_reg <= '0;
      lo_reg <= 1'b0;
      hlen_reg <= '0;
      s2m_valid_reg <= 1'b0;
      s2m_data_reg <= '0;
      drive_reg <= 1'b0;
      exec_valid_reg <= 1'b0;
      func_reg <= '0;
      eaddr_reg <= '0;
      ecount_reg <= '0;
      bcast_reg <= 1'b0;
      drop_reg <= 1'b0;
      cerr_reg <= 1'b0;
    end else begin
      s2m_valid_reg <= 1'b0;
      drop_reg <= 1'b0;
      exec_valid_reg <= exec_go;
      cerr_reg <= link.m2s_valid & (st_reg != S_RX | (len_reg == '0 & ~quiet_reg));
      pace_reg <= tick ? '0 : pace_reg + 32'd1;
      if (exec_go) begin
        func_reg <= q_fc;
        eaddr_reg <= q_p1;
        ecount_reg <= (q_fc == FC_WRITE1) ? 16'h0001 : q_p2;
        bcast_reg <= bcast;
      end
      case (st_reg)
        S_RX: begin
          if (link.m2s_valid) begin
            gap_reg <= '0;
            quiet_reg <= 1'b0;
            len_reg <= (len_reg > 9'(MAX_FRAME)) ? len_reg : len_reg + 9'd1;
            ovf_reg <= ovf_reg | (len_reg >= 9'(MAX_FRAME));
            err_reg <= err_reg | link.m2s_frame_err | link.m2s_parity_err | (len_reg == '0 & ~quiet_reg);
            crc_reg <= mrsfh_crc_byte(crc_reg, link.m2s_data);
            crc_d1_reg <= crc_reg;
            crc_d2_reg <= crc_d1_reg;
          end else if (gap_reg != 32'(SILENCE_CYCLES)) begin
            gap_reg <= gap_reg + 32'd1;
          end else begin
            quiet_reg <= 1'b1;
          end
          if (frame_end) begin
            st_reg <= S_EVAL;
          end
        end
        S_EVAL: begin
          len_reg <= '0;
          ovf_reg <= 1'b0;
          err_reg <= 1'b0;
          quiet_reg <= 1'b1;
          crc_reg <= CRC_PRESET;
          crc_d1_reg <= CRC_PRESET;
          crc_d2_reg <= CRC_PRESET;
          drop_reg <= ~good;
          if (good && !bcast && mine) begin
            st_reg <= S_HDR;
            exc_reg <= exc;
            hlen_reg <= (exc != EXC_NONE || rd_fn) ? 8'd3 : 8'd6;
            words_reg <= (exc == EXC_NONE && rd_fn) ? q_p2 : '0;
            tx_idx_reg <= '0;
            lo_reg <= 1'b0;
            tx_crc_reg <= CRC_PRESET;
            pace_reg <= 32'(CHAR_CYCLES - 1);
            drive_reg <= 1'b1;
          end else begin
            st_reg <= S_RX;
            gap_reg <= '0;
          end
        end
        S_HDR: begin
          if (tick) begin
            s2m_valid_reg <= 1'b1;
            s2m_data_reg <= hdr_byte;
            tx_crc_reg <= mrsfh_crc_byte(tx_crc_reg, hdr_byte);
            tx_idx_reg <= tx_idx_reg + 8'd1;
            if (last_hdr) begin
              st_reg <= (words_reg != '0) ? S_DATA : S_CRCL;
            end
          end
        end
        S_DATA: begin
          if (tick && fifo_valid) begin
            s2m_valid_reg <= 1'b1;
            s2m_data_reg <= data_byte;
            tx_crc_reg <= mrsfh_crc_byte(tx_crc_reg, data_byte);
            lo_reg <= ~lo_reg;
            if (lo_reg) begin
              words_reg <= words_reg - 16'd1;
              if (words_reg == 16'd1) begin
                st_reg <= S_CRCL;
              end
            end
          end
        end
        S_CRCL: begin
          if (tick) begin
            s2m_valid_reg <= 1'b1;
            s2m_data_reg <= tx_crc_reg[7:0];
            st_reg <= S_CRCH;
          end
        end
        S_CRCH: begin
          if (tick) begin
            s2m_valid_reg <= 1'b1;
            s2m_data_reg <= tx_crc_reg[15:8];
            st_reg <= S_END;
          end
        end
        S_END: begin
          if (tick) begin
            drive_reg <= 1'b0;
            st_reg <= S_RX;
            gap_reg <= '0;
            quiet_reg <= 1'b0;
          end
        end
        default: st_reg <= S_RX;
      endcase
    end
  end

  assign link.s2m_valid = s2m_valid_reg;
  assign link.s2m_data = s2m_data_reg;
  assign link.s2m_drive = drive_reg;
  assign exec_valid = exec_valid_reg;
  assign exec_func = func_reg;
  assign exec_addr = eaddr_reg;
  assign exec_count = ecount_reg;
  assign exec_bcast = bcast_reg;
  assign frame_drop = drop_reg;
  assign comm_err = cerr_reg;
endmodule

// ==== src/mrsfh_pkg.sv ====
// constants, crc step and decode values for the rtu frame handler
// Behaviour
// - query is address, function, data, crc
// - address zero broadcasts, others select one
// - broadcast executes but never answers
// - 03h reads 1 to 125, unicast only
// - 06h writes one register, broadcast allowed
// - 10h writes 1 to 123, broadcast allowed
// - 17h read 125/write 121; 08h unicast
// - crc preset FFFFh, shift right, xor A001h
// - eight shift steps per byte
// - frame valid only when crc matches
// - framing error discards query silently
// - parity error discards query silently
// - crc mismatch discards query silently
// - frames over 256 bytes discarded silently
// - foreign station address stays silent
// - valid query gets function specific response
// - exception is address, function, code, crc
// - exception function is query function plus 80h
// - codes 01h function, 02h address, 03h data, 04h busy
// - 3.5 character silence bounds frames
package mrsfh_pkg;
  localparam longint CLK_HZ = 125_000_000;
  localparam longint BAUD = 9600;
  localparam longint CHAR_BITS = 11;
  localparam int CHAR_CYCLES_DEF = int'((CLK_HZ * CHAR_BITS + BAUD - 1) / BAUD);
  localparam int SILENCE_X2 = 7;
  localparam int SILENCE_CYCLES_DEF = (CHAR_CYCLES_DEF * SILENCE_X2 + 1) / 2;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int CRC_STEPS = 8;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] FC_RDWR = 8'h17;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h04;
  localparam logic [15:0] RD_MAX = 16'h007D;
  localparam logic [15:0] WRN_MAX = 16'h007B;
  localparam logic [15:0] RW_WMAX = 16'h0079;
  localparam logic [16:0] REG_LIMIT = 17'h05800;
  localparam logic [15:0] DIAG_SUB = 16'h0000;
  localparam int MAX_FRAME = 256;
  localparam logic [8:0] MIN_FRAME = 9'h004;
  localparam logic [8:0] WRITE1_LEN = 9'h008;
  localparam int RD_FIFO_DEPTH = 32;

  function automatic logic [15:0] mrsfh_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < CRC_STEPS; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ==== src/mrsfh_link_if.sv ====
// character link between the bus master end and the slave end
interface mrsfh_link_if;
  logic m2s_valid;
  logic [7:0] m2s_data;
  logic m2s_frame_err;
  logic m2s_parity_err;
  logic s2m_valid;
  logic [7:0] s2m_data;
  logic s2m_drive;
  modport master (output m2s_valid, m2s_data, m2s_frame_err, m2s_parity_err,
                  input s2m_valid, s2m_data, s2m_drive);
  modport slave (input m2s_valid, m2s_data, m2s_frame_err, m2s_parity_err,
                 output s2m_valid, s2m_data, s2m_drive);
endinterface

// ==== src/mrsfh_master.sv ====
// master end: paced query sender with crc and response collector
module mrsfh_master import mrsfh_pkg::*; #(
  parameter int CHAR_CYCLES = CHAR_CYCLES_DEF,
  parameter int SILENCE_CYCLES = SILENCE_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link to the slave
  mrsfh_link_if.master link,
  // query bytes from the user
  input wire logic q_valid,
  input wire logic [7:0] q_data,
  input wire logic q_last,
  input wire logic q_ferr,
  input wire logic q_perr,
  output logic q_ready,
  // response bytes to the user
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_done,
  output logic rsp_ok,
  output logic [8:0] rsp_len
);
  typedef enum {M_IDLE, M_SEND, M_CRCL, M_CRCH} mrsfh_mstate_t;
  mrsfh_mstate_t st_reg;
  logic [31:0] gap_reg, pace_reg;
  logic [15:0] crc_reg, rcrc_reg, rd1_reg, rd2_reg;
  logic [7:0] b1_reg, b2_reg;
  logic [8:0] rlen_reg;
  logic rdy_reg, mv_reg, fe_reg, pe_reg, rv_reg, done_reg, ok_reg;
  logic [7:0] md_reg, rdat_reg;
  logic [8:0] len_out_reg;

  wire quiet = (gap_reg == 32'(SILENCE_CYCLES)) & ~link.s2m_drive;
  wire tick = pace_reg == 32'(CHAR_CYCLES - 1);
  wire take = q_valid & rdy_reg;
  wire busy_link = link.s2m_valid | link.s2m_drive | mv_reg;
  wire rend = (rlen_reg != '0) & (gap_reg == 32'(SILENCE_CYCLES - 1)) & ~busy_link;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= M_IDLE;
      gap_reg <= '0;
      pace_reg <= '0;
      crc_reg <= CRC_PRESET;
      rcrc_reg <= CRC_PRESET;
      rd1_reg <= CRC_PRESET;
      rd2_reg <= CRC_PRESET;
      b1_reg <= '0;
      b2_reg <= '0;
      rlen_reg <= '0;
      rdy_reg <= 1'b0;
      mv_reg <= 1'b0;
      md_reg <= '0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      rv_reg <= 1'b0;
      rdat_reg <= '0;
      done_reg <= 1'b0;
      ok_reg <= 1'b0;
      len_out_reg <= '0;
    end else begin
      mv_reg <= 1'b0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      rv_reg <= link.s2m_valid;
      done_reg <= rend;
      pace_reg <= tick ? '0 : pace_reg + 32'd1;
      gap_reg <= busy_link ? '0 : (gap_reg == 32'(SILENCE_CYCLES) ? gap_reg : gap_reg + 32'd1);
      rdy_reg <= ~take & ((st_reg == M_IDLE & quiet) | (st_reg == M_SEND & tick));
      if (link.s2m_valid) begin
        rdat_reg <= link.s2m_data;
        rcrc_reg <= mrsfh_crc_byte(rcrc_reg, link.s2m_data);
        rd1_reg <= rcrc_reg;
        rd2_reg <= rd1_reg;
        b1_reg <= link.s2m_data;
        b2_reg <= b1_reg;
        rlen_reg <= (rlen_reg == 9'h1FF) ? rlen_reg : rlen_reg + 9'd1;
      end else if (rend) begin
        ok_reg <= (rlen_reg >= MIN_FRAME) & (rd2_reg == {b1_reg, b2_reg});
        len_out_reg <= rlen_reg;
        rlen_reg <= '0;
        rcrc_reg <= CRC_PRESET;
        rd1_reg <= CRC_PRESET;
        rd2_reg <= CRC_PRESET;
      end
      case (st_reg)
        M_IDLE, M_SEND: begin
          if (take) begin
            mv_reg <= 1'b1;
            md_reg <= q_data;
            fe_reg <= q_ferr;
            pe_reg <= q_perr;
            crc_reg <= mrsfh_crc_byte((st_reg == M_IDLE) ? CRC_PRESET : crc_reg, q_data);
            pace_reg <= '0;
            st_reg <= q_last ? M_CRCL : M_SEND;
          end
        end
        M_CRCL: begin
          if (tick) begin
            mv_reg <= 1'b1;
            md_reg <= crc_reg[7:0];
            st_reg <= M_CRCH;
          end
        end
        M_CRCH: begin
          if (tick) begin
            mv_reg <= 1'b1;
            md_reg <= crc_reg[15:8];
            st_reg <= M_IDLE;
          end
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end

  assign link.m2s_valid = mv_reg;
  assign link.m2s_data = md_reg;
  assign link.m2s_frame_err = fe_reg;
  assign link.m2s_parity_err = pe_reg;
  assign q_ready = rdy_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = rdat_reg;
  assign rsp_done = done_reg;
  assign rsp_ok = ok_reg;
  assign rsp_len = len_out_reg;
endmodule

// ==== verification/mrsfh_link_properties.sv ====
// link checker for the rtu master and slave ends
module mrsfh_link_properties #(
  parameter int CHAR_CYCLES = 8,
  parameter int SILENCE_CYCLES = 28
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // master to slave characters
  input wire logic m2s_valid,
  input wire logic [7:0] m2s_data,
  input wire logic m2s_frame_err,
  input wire logic m2s_parity_err,
  // slave to master characters
  input wire logic s2m_valid,
  input wire logic [7:0] s2m_data,
  input wire logic s2m_drive
);
  logic [9:0] rx_quiet_reg;
  logic [9:0] tx_quiet_reg;
  // cycles since the last query character and since the driver was last on
  always_ff @(posedge core_clk) begin
    if (reset || m2s_valid) rx_quiet_reg <= 10'h000;
    else if (rx_quiet_reg != 10'h3FF) rx_quiet_reg <= rx_quiet_reg + 10'h001;
  end
  always_ff @(posedge core_clk) begin
    if (reset || s2m_drive) tx_quiet_reg <= 10'h000;
    else if (tx_quiet_reg != 10'h3FF) tx_quiet_reg <= tx_quiet_reg + 10'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  tx_needs_drive_a: assert property (s2m_valid |-> s2m_drive)
    else $error("slave character without line driver");
  drive_starts_tx_a: assert property ($rose(s2m_drive) |=> s2m_valid)
    else $error("line driver on without first character");
  drive_releases_a: assert property (s2m_valid |-> ##[1:9] (s2m_valid || !s2m_drive))
    else $error("line driver held after response");
  half_duplex_a: assert property (s2m_drive |-> !m2s_valid)
    else $error("query character while slave drives");
  rx_pacing_a: assert property (m2s_valid |=> !m2s_valid [*7])
    else $error("query characters too close");
  tx_pacing_a: assert property (s2m_valid |=> !s2m_valid [*7])
    else $error("response characters too close");
  err_with_char_a: assert property ((m2s_frame_err || m2s_parity_err) |-> m2s_valid)
    else $error("error flag without character");
  tx_after_gap_a: assert property ($rose(s2m_drive) |-> rx_quiet_reg >= 10'(SILENCE_CYCLES - 2))
    else $error("response before frame silence");
  rx_after_gap_a: assert property (m2s_valid |-> tx_quiet_reg >= 10'(SILENCE_CYCLES - CHAR_CYCLES - 2))
    else $error("query before response silence");
endmodule

// ==== verification/tb.sv ====
// self-checking bench joining the master and slave ends
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("unexpected %s exp %h saw %h", n, e, s); end end
module tb import mrsfh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mrsfh_bytes_t[$];
  localparam int CC = 8;
  localparam int SC = 28;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic q_valid, q_last, q_ferr, q_perr, slave_busy, rd_valid;
  logic [7:0] q_data, station_addr, rsp_data, exec_func;
  logic [15:0] rd_data, exec_addr, exec_count;
  logic q_ready, rsp_valid, rsp_done, rsp_ok, exec_valid, exec_bcast, rd_ready, frame_drop, comm_err;
  logic [8:0] rsp_len;
  mrsfh_bytes_t rq, wq, lq;
  int num_errors, checks, n_exec, n_drop, n_cerr, pidx, cyc;
  always #4 core_clk = ~core_clk;
  mrsfh_link_if link ();
  mrsfh_master #(.CHAR_CYCLES(CC), .SILENCE_CYCLES(SC)) u_mrsfh_master (.core_clk, .reset, .link(link.master),
    .q_valid, .q_data, .q_last, .q_ferr, .q_perr, .q_ready, .rsp_valid, .rsp_data, .rsp_done, .rsp_ok, .rsp_len);
  mrsfh_slave #(.CHAR_CYCLES(CC), .SILENCE_CYCLES(SC), .FIFO_DEPTH(32)) u_mrsfh_slave (.core_clk, .reset,
    .link(link.slave), .station_addr, .slave_busy, .exec_valid, .exec_func, .exec_addr, .exec_count,
    .exec_bcast, .rd_valid, .rd_data, .rd_ready, .frame_drop, .comm_err);
  mrsfh_link_properties #(.CHAR_CYCLES(CC), .SILENCE_CYCLES(SC)) u_props (.core_clk, .reset,
    .m2s_valid(link.m2s_valid), .m2s_data(link.m2s_data), .m2s_frame_err(link.m2s_frame_err),
    .m2s_parity_err(link.m2s_parity_err), .s2m_valid(link.s2m_valid), .s2m_data(link.s2m_data),
    .s2m_drive(link.s2m_drive));
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // collectors and read word source; each accepted word counts up
  always @(posedge core_clk) begin
    cyc++;
    if (rsp_valid === 1'b1) rq.push_back(rsp_data);
    if (link.m2s_valid === 1'b1) wq.push_back(link.m2s_data);
    if (exec_valid === 1'b1) n_exec++;
    if (frame_drop === 1'b1) n_drop++;
    if (comm_err === 1'b1) n_cerr++;
    if (!reset && rd_valid && rd_ready === 1'b1) rd_data <= #1 rd_data + 16'h0001;
    if (cyc == 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] crc(input mrsfh_bytes_t b);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  function automatic mrsfh_bytes_t mk(input logic [103:0] v, input int n);
    mrsfh_bytes_t r;
    for (int i = n - 1; i >= 0; i--) r.push_back(v[8*i +: 8]);
    return r;
  endfunction
  // kind: 0 silent, 1 echo of bytes 0-5, 2 exception, 3 read words
  task automatic run(input mrsfh_bytes_t b, input int kind, input logic [7:0] code, input int ex,
                     input int dr, input int fe = -1, input int pe = -1);
    mrsfh_bytes_t e;
    logic [15:0] c, w;
    int t, n0, d0;
    n0 = n_exec;
    d0 = n_drop;
    wq.delete();
    rq.delete();
    foreach (b[i]) begin
      q_valid = 1'b1;
      q_data = b[i];
      q_last = (i == b.size() - 1);
      q_ferr = (i == fe);
      q_perr = (i == pe);
      for (t = 0; t < 3000 && q_ready !== 1'b1; t++) tick(1);
      tick(1);
    end
    {q_valid, q_last, q_ferr, q_perr} = 4'h0;
    if (kind == 0) tick(2 * CC + SC + 24);
    else for (t = 0; t < 3000 && rsp_done !== 1'b1; t++) tick(1);
    c = crc(b);
    `CHK("wire_len", b.size() + 2, wq.size())
    `CHK("wire_crc", ({c[7:0], c[15:8]}), ({wq[b.size()], wq[b.size() + 1]}))
    if (kind == 1) e = b[0:5];
    if (kind == 2) e = {b[0], b[1] | 8'h80, code};
    if (kind == 3) begin
      e = {b[0], b[1], 8'(2 * b[5])};
      repeat (b[5]) begin
        w = 16'h1000 + 16'(pidx);
        pidx++;
        e.push_back(w[15:8]);
        e.push_back(w[7:0]);
      end
    end
    if (kind != 0) begin
      c = crc(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      `CHK("rsp_ok", 1'b1, rsp_ok)
      `CHK("rsp_len", 9'(e.size()), rsp_len)
    end
    `CHK("rsp_count", e.size(), rq.size())
    foreach (e[i]) `CHK("rsp_byte", e[i], rq[i])
    if (ex >= 0) `CHK("exec", ex, n_exec - n0)
    `CHK("drop", dr, n_drop - d0)
  endtask
  initial begin
    {q_valid, q_last, q_ferr, q_perr, slave_busy} = 5'h00;
    q_data = 8'h00;
    station_addr = 8'h11;
    rd_valid = 1'b1;
    rd_data = 16'h1000;
    tick(2);
    reset = 1'b0;
    tick(40);
    `CHK("fifo_full", 1'b0, rd_ready)
    run(mk(48'h110600101234, 6), 1, 8'h00, 1, 0);
    `CHK("func", FC_WRITE1, exec_func)
    `CHK("addr", 16'h0010, exec_addr)
    `CHK("bcast", 1'b0, exec_bcast)
    run(mk(72'h00100020000102ABCD, 9), 0, 8'h00, 1, 0);
    `CHK("bcast", 1'b1, exec_bcast)
    `CHK("count", 16'h0001, exec_count)
    run(mk(48'h000600101234, 6), 0, 8'h00, 1, 0);
    run(mk(48'h000300000001, 6), 0, 8'h00, 0, 0);
    run(mk(48'h000800001234, 6), 0, 8'h00, 0, 0);
    run(mk(48'h110300000002, 6), 3, 8'h00, 1, 0);
    run(mk(88'h1110002000020411223344, 11), 1, 8'h00, 1, 0);
    run(mk(104'h11170000000100300001025566, 13), 3, 8'h00, 1, 0);
    run(mk(48'h110800001234, 6), 1, 8'h00, 1, 0);
    run(mk(48'h110500000001, 6), 2, 8'h01, 0, 0);
    run(mk(48'h110800011234, 6), 2, 8'h01, 0, 0);
    run(mk(48'h110358000001, 6), 2, 8'h02, 0, 0);
    run(mk(48'h11030000007E, 6), 2, 8'h03, 0, 0);
    run(mk(48'h110300000000, 6), 2, 8'h03, 0, 0);
    run(mk(56'h11100000007CF8, 7), 2, 8'h03, 0, 0);
    run(mk(88'h1117000000010030007AF4, 11), 2, 8'h03, 0, 0);
    slave_busy = 1'b1;
    run(mk(48'h110600101234, 6), 2, 8'h04, 0, 0);
    slave_busy = 1'b0;
    run(mk(48'h120600101234, 6), 0, 8'h00, 0, 0);
    run(mk(48'h110600101234, 6), 0, 8'h00, 0, 1, 2);
    run(mk(48'h110600101234, 6), 0, 8'h00, 0, 1, -1, 3);
    run(mk(8'h11, 1), 0, 8'h00, 0, 1);
    lq = mk(16'h1110, 2);
    repeat (253) lq.push_back(8'h5A);
    run(lq, 0, 8'h00, 0, 1);
    rd_valid = 1'b0;
    run(mk(48'h110300000020, 6), 3, 8'h00, 1, 0);
    rd_valid = 1'b1;
    `CHK("comm_err", 0, n_cerr)
    print_verdict();
  end
endmodule
